// ---- verilog/rrse_params.svh ----
// Constants for the return, rotate, subtract-with-borrow execution block
`ifndef RRSE_PARAMS_SVH
`define RRSE_PARAMS_SVH
`define RRSE_DATA_W 8
`define RRSE_RADDR_W 7
`define RRSE_SADDR_W 5
`define RRSE_SPAGE_MAX 5'h15
`define RRSE_PC_W 11
`define RRSE_STK_DEPTH 8
`define RRSE_LVL_W 4
`define RRSE_MSB 7
`define RRSE_NIB 4
`define RRSE_DEST_ACC 1'b0
`define RRSE_DEST_REG 1'b1
`define RRSE_RET_CYCLES 2'h2
`define RRSE_ACC_RST 8'h00
`define RRSE_PC_RST 11'h000
`endif

// ---- verilog/rrse_pkg.sv ----
// Types shared by the execution block
package rrse_pkg;
    typedef enum logic [5:0] {
        RRSE_OP_NONE = 6'h01,
        RRSE_OP_RET = 6'h02,
        RRSE_OP_RRC = 6'h04,
        RRSE_OP_SBR = 6'h08,
        RRSE_OP_SBI = 6'h10,
        RRSE_OP_SST = 6'h20
    } rrse_op_type;
    typedef enum logic [1:0] {
        RRSE_ST_RUN = 2'h1,
        RRSE_ST_RET2 = 2'h2
    } rrse_state_type;
endpackage

// ---- verilog/rrse_sub_borrow.sv ----
// Adder computing a + ~acc + carry with flag outputs
`timescale 1ns/1ps
`include "rrse_params.svh"
module rrse_sub_borrow
    import rrse_pkg::*;
(
    input wire logic [`RRSE_DATA_W-1:0] a,
    input wire logic [`RRSE_DATA_W-1:0] acc,
    input wire logic cin,
    output logic [`RRSE_DATA_W-1:0] result,
    output logic zero,
    output logic half_carry,
    output logic carry
);
    logic [`RRSE_NIB:0] low_sum;
    logic [`RRSE_DATA_W:0] full_sum;
    // Low nibble gives the half carry, full byte the carry
    always_comb begin
        low_sum = {1'b0, a[`RRSE_NIB-1:0]} + {1'b0, ~acc[`RRSE_NIB-1:0]}
            + {{`RRSE_NIB{1'b0}}, cin};
        full_sum = {1'b0, a} + {1'b0, ~acc}
            + {{`RRSE_DATA_W{1'b0}}, cin};
        result = full_sum[`RRSE_DATA_W-1:0];
        zero = (full_sum[`RRSE_DATA_W-1:0] == `RRSE_ACC_RST);
        half_carry = low_sum[`RRSE_NIB];
        carry = full_sum[`RRSE_DATA_W]; // RL7
    end
endmodule

// ---- verilog/rrse_exec.sv ----
// Execution unit for return, rotate, subtract-with-borrow, S-page store
// Functional notes
// [RL1] Return loads PC from stack top, drops level by one, takes 2 cycles.
// [RL2] Rotate right moves old carry into bit 7 and source bit 0 to carry.
// [RL3] Destination bit 0 writes the accumulator, 1 writes register 0..127.
// [RL4] Register subtract computes R + ~acc + C and updates Z, DC, C.
// [RL5] Immediate subtract computes i + ~acc + C into the accumulator only.
// [RL6] S-page store copies the accumulator to S-page index 0..21, no flags.
// [RL7] Rotate, subtracts and store take one cycle; carry set means no borrow.
`timescale 1ns/1ps
`include "rrse_params.svh"
module rrse_exec
    import rrse_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic op_valid,
    input wire rrse_op_type op,
    input wire logic [`RRSE_RADDR_W-1:0] reg_addr,
    input wire logic dest_sel,
    input wire logic [`RRSE_DATA_W-1:0] imm,
    input wire logic [`RRSE_SADDR_W-1:0] spage_addr,
    input wire logic [`RRSE_DATA_W-1:0] reg_rdata,
    input wire logic push_valid,
    input wire logic [`RRSE_PC_W-1:0] push_pc,
    output logic busy_ff,
    output logic [`RRSE_DATA_W-1:0] working_accumulator_ff,
    output logic carry_ff,
    output logic half_carry_flag_ff,
    output logic zero_ff,
    output logic reg_we_ff,
    output logic [`RRSE_RADDR_W-1:0] reg_waddr_ff,
    output logic [`RRSE_DATA_W-1:0] reg_wdata_ff,
    output logic spage_we_ff,
    output logic [`RRSE_SADDR_W-1:0] spage_waddr_ff,
    output logic [`RRSE_DATA_W-1:0] spage_wdata_ff,
    output logic pc_load_ff,
    output logic [`RRSE_PC_W-1:0] pc_ff,
    output logic [`RRSE_LVL_W-1:0] stack_level_ff,
    output logic stack_err_ff
);
    // State, stack storage and decode helpers
    rrse_state_type state_ff;
    logic [`RRSE_PC_W-1:0] stack_ff [`RRSE_STK_DEPTH];
    logic [`RRSE_DATA_W-1:0] sub_a;
    logic [`RRSE_DATA_W-1:0] sub_res;
    logic sub_z;
    logic sub_dc;
    logic sub_c;
    logic take;
    logic is_sub;
    logic [`RRSE_DATA_W-1:0] nxt_result;
    logic nxt_to_reg;
    logic stack_empty;
    logic stack_full;
    logic [`RRSE_LVL_W-1:0] top_idx;
    logic ret_take;
    logic push_ok;

    // Issue gate and stack bounds
    assign take = op_valid && (state_ff == RRSE_ST_RUN);
    assign is_sub = (op == RRSE_OP_SBR) || (op == RRSE_OP_SBI);
    assign stack_empty = (stack_level_ff == {`RRSE_LVL_W{1'b0}});
    assign stack_full = (stack_level_ff == `RRSE_LVL_W'(`RRSE_STK_DEPTH));
    assign top_idx = stack_level_ff - `RRSE_LVL_W'(1);
    // A return in the same cycle wins over a push
    assign ret_take = take && (op == RRSE_OP_RET);
    assign push_ok = push_valid && !stack_full && !ret_take;
    // Subtract source: register or immediate
    assign sub_a = (op == RRSE_OP_SBI) ? imm : reg_rdata; // RL4 RL5

    rrse_sub_borrow u_sub (
        .a(sub_a),
        .acc(working_accumulator_ff),
        .cin(carry_ff),
        .result(sub_res),
        .zero(sub_z),
        .half_carry(sub_dc),
        .carry(sub_c)
    );

    // Result and destination selection
    always_comb begin
        nxt_result = sub_res;
        nxt_to_reg = 1'b0;
        case (op)
            RRSE_OP_RRC: begin
                nxt_result = {carry_ff, reg_rdata[`RRSE_MSB:1]}; // RL2
                nxt_to_reg = (dest_sel == `RRSE_DEST_REG); // RL3
            end
            RRSE_OP_SBR: begin
                nxt_result = sub_res; // RL4
                nxt_to_reg = (dest_sel == `RRSE_DEST_REG); // RL3
            end
            RRSE_OP_SBI: begin
                nxt_result = sub_res;
                nxt_to_reg = 1'b0; // RL5
            end
            default: begin
                nxt_result = sub_res;
                nxt_to_reg = 1'b0;
            end
        endcase
    end

    // Return sequencer: second cycle of return holds off new ops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= RRSE_ST_RUN;
            busy_ff <= 1'b0;
        end else begin
            case (state_ff)
                RRSE_ST_RUN: begin
                    if (take && op == RRSE_OP_RET) begin
                        state_ff <= RRSE_ST_RET2; // RL1
                        busy_ff <= 1'b1;
                    end
                end
                RRSE_ST_RET2: begin
                    state_ff <= RRSE_ST_RUN; // RL1
                    busy_ff <= 1'b0;
                end
                default: begin
                    state_ff <= RRSE_ST_RUN;
                    busy_ff <= 1'b0;
                end
            endcase
        end
    end

    // Accumulator and flags, single-cycle update
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            working_accumulator_ff <= `RRSE_ACC_RST;
            carry_ff <= 1'b0;
            half_carry_flag_ff <= 1'b0;
            zero_ff <= 1'b0;
        end else if (take) begin
            if ((op == RRSE_OP_RRC || is_sub) && !nxt_to_reg) begin
                working_accumulator_ff <= nxt_result; // RL3 RL7
            end
            if (op == RRSE_OP_RRC) begin
                carry_ff <= reg_rdata[0]; // RL2
            end
            if (is_sub) begin
                carry_ff <= sub_c; // RL4 RL5 RL7
                half_carry_flag_ff <= sub_dc;
                zero_ff <= sub_z;
            end
        end
    end

    // Register file write port
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_we_ff <= 1'b0;
            reg_waddr_ff <= {`RRSE_RADDR_W{1'b0}};
            reg_wdata_ff <= `RRSE_ACC_RST;
        end else begin
            reg_we_ff <= take && (op == RRSE_OP_RRC || op == RRSE_OP_SBR)
                && nxt_to_reg; // RL3
            reg_waddr_ff <= reg_addr;
            reg_wdata_ff <= nxt_result;
        end
    end

    // S-page write port; out-of-range index is dropped
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            spage_we_ff <= 1'b0;
            spage_waddr_ff <= {`RRSE_SADDR_W{1'b0}};
            spage_wdata_ff <= `RRSE_ACC_RST;
        end else begin
            spage_we_ff <= take && (op == RRSE_OP_SST)
                && (spage_addr <= `RRSE_SPAGE_MAX); // RL6
            spage_waddr_ff <= spage_addr;
            spage_wdata_ff <= working_accumulator_ff; // RL6
        end
    end

    // Stack storage, one entry per level
    genvar gi;
    generate
        for (gi = 0; gi < `RRSE_STK_DEPTH; gi = gi + 1) begin : g_stk
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    stack_ff[gi] <= `RRSE_PC_RST;
                end else if (push_ok
                    && stack_level_ff == `RRSE_LVL_W'(gi)) begin
                    stack_ff[gi] <= push_pc;
                end
            end
        end
    endgenerate

    // Stack level, PC load and underflow/overflow flag
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stack_level_ff <= {`RRSE_LVL_W{1'b0}};
            pc_load_ff <= 1'b0;
            pc_ff <= `RRSE_PC_RST;
            stack_err_ff <= 1'b0;
        end else begin
            pc_load_ff <= 1'b0;
            if (take && op == RRSE_OP_RET) begin
                if (stack_empty) begin
                    stack_err_ff <= 1'b1;
                end else begin
                    pc_ff <= stack_ff[top_idx[2:0]]; // RL1
                    pc_load_ff <= 1'b1;
                    stack_level_ff <= top_idx; // RL1
                end
            end else if (push_valid) begin
                if (stack_full) begin
                    stack_err_ff <= 1'b1;
                end else begin
                    stack_level_ff <= stack_level_ff + `RRSE_LVL_W'(1);
                end
            end
        end
    end
endmodule

// ---- tb/rrse_exec_properties.sv ----
// Port assertions for the execution block
`timescale 1ns/1ps
`include "rrse_params.svh"
module rrse_exec_chk
    import rrse_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic op_valid,
    input wire rrse_op_type op,
    input wire logic dest_sel,
    input wire logic [7:0] imm,
    input wire logic [4:0] spage_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic busy_ff,
    input wire logic [7:0] working_accumulator_ff,
    input wire logic carry_ff,
    input wire logic zero_ff,
    input wire logic reg_we_ff,
    input wire logic spage_we_ff,
    input wire logic [7:0] spage_wdata_ff,
    input wire logic pc_load_ff,
    input wire logic [3:0] stack_level_ff,
    input wire logic stack_err_ff
);
    logic go;
    logic [8:0] sbr_sum;
    logic [7:0] sbi_sum;
    // Taken operation and expected sums
    assign go = op_valid && !busy_ff;
    assign sbr_sum = reg_rdata + {1'b0, ~working_accumulator_ff} + carry_ff;
    assign sbi_sum = imm + ~working_accumulator_ff + carry_ff;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Load pulse with busy, then free
    sequence ret_tail;
        pc_load_ff && busy_ff ##1 !pc_load_ff && !busy_ff;
    endsequence
    ret_pop_a: assert property (
        go && op == RRSE_OP_RET && stack_level_ff != 4'h0 |=> ret_tail
        and stack_level_ff == $past(stack_level_ff) - 4'h1)
        else $error("return pop wrong");
    ret_empty_a: assert property (
        go && op == RRSE_OP_RET && stack_level_ff == 4'h0
        |=> stack_err_ff && !pc_load_ff) else $error("empty pop wrong");
    rrc_rot_a: assert property (
        go && op == RRSE_OP_RRC && !dest_sel
        |=> carry_ff == $past(reg_rdata[0])
        && working_accumulator_ff == {$past(carry_ff), $past(reg_rdata[7:1])})
        else $error("rotate wrong");
    dest_reg_a: assert property (
        go && (op == RRSE_OP_RRC || op == RRSE_OP_SBR) && dest_sel
        |=> reg_we_ff && $stable(working_accumulator_ff))
        else $error("register destination wrong");
    sbr_flags_a: assert property (
        go && op == RRSE_OP_SBR |=> carry_ff == $past(sbr_sum[8])
        && zero_ff == ($past(sbr_sum[7:0]) == 8'h00))
        else $error("sbr flags");
    sbi_acc_a: assert property (
        go && op == RRSE_OP_SBI |=> !reg_we_ff
        && working_accumulator_ff == $past(sbi_sum)) else $error("sbi result");
    sst_write_a: assert property (
        go && op == RRSE_OP_SST && spage_addr <= 5'h15 |=> spage_we_ff
        && spage_wdata_ff == $past(working_accumulator_ff) && $stable(carry_ff))
        else $error("spage store wrong");
    sst_skip_a: assert property (
        go && op == RRSE_OP_SST && spage_addr > 5'h15 |=> !spage_we_ff)
        else $error("spage index not refused");
    busy_hold_a: assert property (
        busy_ff |=> $stable(working_accumulator_ff) && $stable(carry_ff)
        && !reg_we_ff && !spage_we_ff) else $error("op taken while busy");
endmodule
bind rrse_exec rrse_exec_chk chk_u (.*);

// ---- tb/rrse_exec_tb.sv ----
// Self-checking bench for the execution block
`timescale 1ns/1ps
`include "rrse_params.svh"
module rrse_exec_tb
    import rrse_pkg::*;
;
    logic clk = 0, reset_n = 0, op_valid = 0, dest_sel = 0, push_valid = 0;
    rrse_op_type op = RRSE_OP_NONE;
    logic [6:0] reg_addr = 7'h7f, reg_waddr_ff;
    logic [7:0] imm = 8'h00, reg_rdata = 8'h00, working_accumulator_ff;
    logic [7:0] reg_wdata_ff, spage_wdata_ff;
    logic [4:0] spage_addr = 5'h00, spage_waddr_ff;
    logic [10:0] push_pc = 11'h000, pc_ff;
    logic [3:0] stack_level_ff;
    logic busy_ff, carry_ff, half_carry_flag_ff, zero_ff, reg_we_ff;
    logic spage_we_ff, pc_load_ff, stack_err_ff;
    int error_cnt = 0, check_count = 0;
    logic [7:0] a = 8'h00;
    logic c = 0, h = 0, z = 0;
    rrse_exec dut_u (.*);
    // Clock and watchdog
    always #5 clk = ~clk;
    initial begin
        #5000;
        error_cnt++;
        test_done;
    end
    task chk(input string n, input logic [10:0] e, input logic [10:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task test_done;
        if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task go(input rrse_op_type o, input logic [7:0] r, input logic d,
            input logic [7:0] i, input logic [4:0] s);
        @(posedge clk);
        op_valid <= 1'b1;
        op <= o;
        reg_rdata <= r;
        reg_addr <= r[6:0];
        dest_sel <= d;
        imm <= i;
        spage_addr <= s;
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
    endtask
    // One operation with the expected result worked out first
    task alu(input rrse_op_type o, input logic [7:0] r, input logic d,
             input logic [7:0] i, input logic [4:0] s);
        logic [7:0] v, x;
        logic [8:0] t;
        logic q, w;
        v = (o == RRSE_OP_SBI) ? i : r;
        t = v + {1'b0, ~a} + c;
        q = ({1'b0, v[3:0]} + {1'b0, ~a[3:0]} + c) > 5'hf;
        x = (o == RRSE_OP_RRC) ? {c, r[7:1]} : t[7:0];
        w = (o == RRSE_OP_RRC || o == RRSE_OP_SBR) && d;
        go(o, r, d, i, s);
        if (o == RRSE_OP_RRC) c = r[0];
        if (o == RRSE_OP_SBR || o == RRSE_OP_SBI) begin
            c = t[8];
            h = q;
            z = (x == 8'h00);
        end
        if (w) chk("wdata", x, reg_wdata_ff);
        else if (o != RRSE_OP_SST && o != RRSE_OP_NONE) a = x;
        if (w) chk("waddr", r[6:0], reg_waddr_ff);
        if (o == RRSE_OP_SST && s <= 5'h15) begin
            chk("sdata", a, spage_wdata_ff);
            chk("saddr", s, spage_waddr_ff);
        end
        chk("acc", a, working_accumulator_ff);
        chk("carry", c, carry_ff);
        chk("hc", h, half_carry_flag_ff);
        chk("zero", z, zero_ff);
        chk("rwe", w, reg_we_ff);
        chk("swe", o == RRSE_OP_SST && s <= 5'h15, spage_we_ff);
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        chk("level", 4'h0, stack_level_ff);
        chk("busy", 1'b0, busy_ff);
        chk("err", 1'b0, stack_err_ff);
        chk("pc", 11'h000, pc_ff);
        for (int k = 1; k <= 3; k++) begin
            @(posedge clk);
            push_valid <= 1'b1;
            push_pc <= 11'h7f0 + 11'(k);
            @(posedge clk);
            push_valid <= 1'b0;
        end
        alu(RRSE_OP_SBI, 8'h00, 1'b0, 8'h06, 5'h00);
        alu(RRSE_OP_SBR, 8'h06, 1'b1, 8'h00, 5'h00);
        alu(RRSE_OP_SBR, 8'h05, 1'b0, 8'h00, 5'h00);
        alu(RRSE_OP_SBI, 8'h00, 1'b1, 8'hfe, 5'h00);
        alu(RRSE_OP_SBR, 8'h05, 1'b0, 8'h00, 5'h00);
        alu(RRSE_OP_RRC, 8'ha5, 1'b1, 8'h00, 5'h00);
        alu(RRSE_OP_RRC, 8'ha5, 1'b0, 8'h00, 5'h00);
        alu(RRSE_OP_SST, 8'h00, 1'b0, 8'h00, 5'h15);
        alu(RRSE_OP_SST, 8'h00, 1'b0, 8'h00, 5'h16);
        alu(RRSE_OP_NONE, 8'h5a, 1'b1, 8'h00, 5'h00);
        // Return, with a second op arriving in the busy cycle
        @(posedge clk);
        op_valid <= 1'b1;
        op <= RRSE_OP_RET;
        @(posedge clk);
        op <= RRSE_OP_SBI;
        imm <= 8'h33;
        #1;
        chk("pcload", 1'b1, pc_load_ff);
        chk("pc", 11'h7f3, pc_ff);
        chk("level", 4'h2, stack_level_ff);
        chk("busy", 1'b1, busy_ff);
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
        chk("busy", 1'b0, busy_ff);
        chk("acc", a, working_accumulator_ff);
        for (int k = 2; k >= 0; k--) begin
            go(RRSE_OP_RET, 8'h00, 1'b0, 8'h00, 5'h00);
            chk("pcload", k > 0, pc_load_ff);
            if (k > 0) chk("pc", 11'h7f0 + 11'(k), pc_ff);
            chk("err", k == 0, stack_err_ff);
        end
        test_done;
    end
endmodule
